/* rtl/check_register.sv */
// What this block does
// - Write register loads the bus byte when the end-tap readout clock falls.
// - Write-character request clears every write register stage.
// - Long-check state at count one forces bus bits P,0,1,2,4,5 high.
// - Count zero after last byte in finish/mark: strobe, force, preset four.
// - Preset strobe and check force end once the nonzero flag sets.
// - Buffer request rises; three blank slots, cyclic character in fourth.
// - After cyclic character, zero count gives long strobe and four-preset.
// - Long strobe with tape mark also sets count bit c: count eight.
// - Check register only builds the write character, never checks reads.
// - Data enters the check register only with forward direction selected.
// - Phase flip-flop toggles per check clock, cleared by general reset.
// - Check clock: early tap in readout, then end tap while phase set.
// - Shift with stage nine set: stages 4-7 complement, stage one sets.
// - Shift with stage nine clear: plain rotate, stage nine into one.
// - XOR phase loads each stage with itself XOR its data bit.
// - Check register is clear before the first byte of a record.
// - Cyclic character is final contents inverted except positions 4, 6.
package tape_check_pkg;
	localparam int unsigned  CHAR_W           = 9;
	localparam int unsigned  CNT_W            = 4;
	localparam logic [3:0]   CNT_RESET        = 4'h0;
	localparam logic [3:0]   CNT_CHECK_PRESET = 4'h4;
	localparam logic [3:0]   CNT_MARK_PRESET  = 4'h8;
	// Index 0 is parity P (stage one), index k is data bit k-1
	localparam logic [8:0]   LONG_FORCE_MASK  = 9'h06f;
	localparam logic [8:0]   CYC_KEEP_MASK    = 9'h028;
	localparam logic [8:0]   SHIFT_CMPL_MASK  = 9'h078;
	localparam logic [8:0]   CHAR_RESET       = 9'h000;
	localparam int unsigned  APB_AW           = 8;
	localparam logic [7:0]   OFF_CTRL         = 8'h00;
	localparam logic [7:0]   OFF_STATUS       = 8'h04;
	localparam logic [7:0]   OFF_CRC          = 8'h08;
	localparam logic [7:0]   OFF_WREG         = 8'h0c;
	localparam int unsigned  CTRL_WRITE       = 0;
	localparam int unsigned  CTRL_FWD         = 1;
	localparam int unsigned  CTRL_FIN         = 2;
	localparam int unsigned  CTRL_TM          = 3;
	localparam int unsigned  CTRL_START       = 4;
	localparam int unsigned  CTRL_GRESET      = 5;
	localparam logic [3:0]   CTRL_RESET       = 4'h0;
	localparam int unsigned  ST_STATE         = 0;
	localparam int unsigned  ST_COUNT         = 4;
	localparam int unsigned  ST_NZ            = 8;
	localparam int unsigned  ST_EQ1           = 9;
	localparam int unsigned  ST_BREQ          = 10;
	localparam int unsigned  ST_PHASE         = 11;
	localparam int unsigned  ST_DONE          = 12;
	typedef enum logic [2:0] {
		st_idle      = 3'b000,
		st_data      = 3'b001,
		st_cyc_wait  = 3'b010,
		st_long_wait = 3'b011,
		st_mark_wait = 3'b100
	} wr_state_e;
endpackage : tape_check_pkg

////////////////////////////////////////////////////////////////////////////////

module check_register #(
	parameter int unsigned W = tape_check_pkg::CHAR_W
) (
	input  wire logic         pclk,            // Clock
	input  wire logic         presetn,         // Async reset, low
	input  wire logic         clear,           // Clear all stages
	input  wire logic         shift_en,        // Shift-phase clock
	input  wire logic         xor_en,          // XOR-phase clock
	input  wire logic [W-1:0] check_input_bit, // Gated data bits
	output logic      [W-1:0] crc              // Stage contents
);
	logic [W-1:0] next_shift;
	logic         check_stage_nine;

	assign check_stage_nine = crc[W-1];

	// Stage nine feeds stage one; with it set, stages 4-7 invert
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_stage
			if (i == 0) begin : g_first
				assign next_shift[i] = check_stage_nine;
			end else begin : g_rest
				assign next_shift[i] = crc[i-1] ^
					(check_stage_nine & tape_check_pkg::SHIFT_CMPL_MASK[i]);
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc <= tape_check_pkg::CHAR_RESET;
		end else if (clear) begin
			crc <= tape_check_pkg::CHAR_RESET;
		end else if (shift_en) begin
			crc <= next_shift;
		end else if (xor_en) begin
			crc <= crc ^ check_input_bit;
		end
	end
endmodule : check_register

/* rtl/tape_write_check_character_gen.sv */
module tape_write_check_character_gen (
	input  wire logic        pclk,                     // Clock, 50 MHz
	input  wire logic        presetn,                  // Async reset, low
	input  wire logic        psel,                     // APB select
	input  wire logic        penable,                  // APB enable
	input  wire logic        pwrite,                   // APB direction
	input  wire logic [7:0]  paddr,                    // APB byte address
	input  wire logic [31:0] pwdata,                   // APB write data
	output logic      [31:0] prdata,                   // APB read data
	output logic             pready,                   // APB ready
	output logic             pslverr,                  // APB error
	input  wire logic [8:0]  bus_data_bit,             // Internal data bus
	input  wire logic        mem_readout_mode,         // Readout memory mode
	input  wire logic        delay_early_tap,          // Early delay tap
	input  wire logic        delay_end_tap,            // End delay tap
	input  wire logic        write_char_request,       // Write char request
	input  wire logic        readout_request_ff,       // Readout request
	input  wire logic        no_priority,              // No fill priority
	input  wire logic        byte_stored,              // Fill added a byte
	output logic      [8:0]  station_write_bits,       // To tape station
	output logic             buffer_request,           // Buffer wants bytes
	output logic             cyc_check_timing_strobe,  // Cyclic preset
	output logic             long_check_timing_strobe, // Long preset
	output logic             check_force,              // Check char force
	output logic             count_bit_a,              // Counter bit a
	output logic             count_bit_b,              // Counter bit b
	output logic             count_bit_c,              // Counter bit c
	output logic             count_nonzero_flag,       // Count not zero
	output logic             count_zero_flag,          // Count zero
	output logic             count_equals_one,         // Count is one
	output logic             not_writing_cyc_check,    // Not cyclic slot
	output logic             long_check_write_state    // Long-check state
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	tape_check_pkg::wr_state_e state;
	tape_check_pkg::wr_state_e next_state;

	logic [3:0] ctrl;
	logic       write_mode;
	logic       forward_select;
	logic       finish_request;
	logic       tape_mark_request;
	logic       start_pulse;
	logic       general_reset;
	logic       seq_done;
	logic       byte_seen;

	logic       apb_write;
	logic       apb_setup;
	logic       addr_hit;
	logic [31:0] next_rdata;
	logic [31:0] status_word;

	logic [3:0] count;
	logic [3:0] next_count;
	logic [3:0] count_less_one;

	logic       readout_clk;
	logic       readout_clk_d;
	logic       readout_fall;
	logic       check_clk;
	logic       check_clk_d;
	logic       check_fall;
	logic       phase;
	logic       shift_en;
	logic       xor_en;

	logic [8:0] crc;
	logic [8:0] check_input_bit;
	logic [8:0] next_wreg;
	logic [8:0] write_reg;

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, unmapped address answers with pslverr

	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign addr_hit  = (paddr == tape_check_pkg::OFF_CTRL)   |
	                   (paddr == tape_check_pkg::OFF_STATUS) |
	                   (paddr == tape_check_pkg::OFF_CRC)    |
	                   (paddr == tape_check_pkg::OFF_WREG);
	assign pslverr   = psel & penable & ~addr_hit;

	assign write_mode        = ctrl[tape_check_pkg::CTRL_WRITE];
	assign forward_select    = ctrl[tape_check_pkg::CTRL_FWD];
	assign finish_request    = ctrl[tape_check_pkg::CTRL_FIN];
	assign tape_mark_request = ctrl[tape_check_pkg::CTRL_TM];

	// Start and general reset are write-one pulses, never stored
	assign start_pulse   = apb_write & (paddr == tape_check_pkg::OFF_CTRL) &
	                       pwdata[tape_check_pkg::CTRL_START];
	assign general_reset = apb_write & (paddr == tape_check_pkg::OFF_CTRL) &
	                       pwdata[tape_check_pkg::CTRL_GRESET];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= tape_check_pkg::CTRL_RESET;
		end else if (apb_write && paddr == tape_check_pkg::OFF_CTRL) begin
			ctrl <= pwdata[3:0];
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[tape_check_pkg::ST_STATE +: 3] = state;
		status_word[tape_check_pkg::ST_COUNT +: 4] = count;
		status_word[tape_check_pkg::ST_NZ]         = count_nonzero_flag;
		status_word[tape_check_pkg::ST_EQ1]        = count_equals_one;
		status_word[tape_check_pkg::ST_BREQ]       = buffer_request;
		status_word[tape_check_pkg::ST_PHASE]      = phase;
		status_word[tape_check_pkg::ST_DONE]       = seq_done;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			tape_check_pkg::OFF_CTRL: begin
				next_rdata[3:0] = ctrl;
			end
			tape_check_pkg::OFF_STATUS: begin
				next_rdata = status_word;
			end
			tape_check_pkg::OFF_CRC: begin
				next_rdata[8:0] = crc;
			end
			tape_check_pkg::OFF_WREG: begin
				next_rdata[8:0] = write_reg;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it stands from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Delay-line phases turned into single-cycle events on their fall

	assign readout_clk = delay_end_tap & mem_readout_mode;
	assign check_clk   = (delay_early_tap & not_writing_cyc_check &
	                      readout_request_ff & no_priority) |
	                     (phase & delay_end_tap);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			readout_clk_d <= 1'b0;
			check_clk_d   <= 1'b0;
		end else begin
			readout_clk_d <= readout_clk;
			check_clk_d   <= check_clk;
		end
	end

	assign readout_fall = readout_clk_d & ~readout_clk;
	assign check_fall   = check_clk_d & ~check_clk;

	////////////////////////////////////////////////////////////////////////
	// Memory character counter; nonzero flag is what ends each preset

	assign count_nonzero_flag = (count != tape_check_pkg::CNT_RESET);
	assign count_zero_flag    = ~count_nonzero_flag;
	assign count_less_one     = count - 4'h1;
	assign count_bit_a        = count_nonzero_flag & count_less_one[0];
	assign count_bit_b        = count_nonzero_flag & count_less_one[1];
	assign count_bit_c        = count_nonzero_flag & count_less_one[2];
	assign count_equals_one   = count_nonzero_flag & ~count_bit_a &
	                            ~count_bit_b & ~count_bit_c;
	assign buffer_request     = write_mode & ~count_bit_c;

	// Strobes are combinational on a zero count; the preset that they make
	// raises the nonzero flag on the next edge, which drops them again
	assign cyc_check_timing_strobe = (state == tape_check_pkg::st_data) &
	                                 count_zero_flag & byte_seen &
	                                 not_writing_cyc_check & write_mode &
	                                 (finish_request | tape_mark_request);
	assign long_check_timing_strobe =
		((state == tape_check_pkg::st_cyc_wait) & count_zero_flag) |
		((state == tape_check_pkg::st_long_wait) & count_zero_flag &
		 tape_mark_request);
	assign check_force = cyc_check_timing_strobe |
	                     long_check_timing_strobe;

	always_comb begin
		next_count = count;
		if (long_check_timing_strobe &&
		    state == tape_check_pkg::st_long_wait) begin
			next_count = tape_check_pkg::CNT_MARK_PRESET;
		end else if (check_force) begin
			next_count = tape_check_pkg::CNT_CHECK_PRESET;
		end else if (byte_stored && !(readout_fall && count_nonzero_flag)) begin
			next_count = count + 4'h1;
		end else if (!byte_stored && readout_fall && count_nonzero_flag) begin
			next_count = count_less_one;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= tape_check_pkg::CNT_RESET;
		end else if (start_pulse) begin
			count <= tape_check_pkg::CNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Record sequence

	assign not_writing_cyc_check  = (state != tape_check_pkg::st_cyc_wait);
	assign long_check_write_state = (state == tape_check_pkg::st_long_wait);

	always_comb begin
		next_state = state;
		case (state)
			tape_check_pkg::st_idle: begin
				if (start_pulse && write_mode) begin
					next_state = tape_check_pkg::st_data;
				end
			end
			tape_check_pkg::st_data: begin
				if (cyc_check_timing_strobe) begin
					next_state = tape_check_pkg::st_cyc_wait;
				end
			end
			tape_check_pkg::st_cyc_wait: begin
				if (long_check_timing_strobe) begin
					next_state = tape_check_pkg::st_long_wait;
				end
			end
			tape_check_pkg::st_long_wait: begin
				if (long_check_timing_strobe) begin
					next_state = tape_check_pkg::st_mark_wait;
				end else if (count_zero_flag) begin
					next_state = tape_check_pkg::st_idle;
				end
			end
			tape_check_pkg::st_mark_wait: begin
				if (count_zero_flag) begin
					next_state = tape_check_pkg::st_idle;
				end
			end
			default: begin
				next_state = tape_check_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tape_check_pkg::st_idle;
		end else if (general_reset) begin
			state <= tape_check_pkg::st_idle;
		end else begin
			state <= next_state;
		end
	end

	// Done sets when the sequence returns to idle, not on a general reset; a start in the same cycle loses to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_done <= 1'b0;
		end else if (state != tape_check_pkg::st_idle &&
		             next_state == tape_check_pkg::st_idle) begin
			seq_done <= 1'b1;
		end else if (start_pulse) begin
			seq_done <= 1'b0;
		end
	end

	// Guards against a record that ends before any byte was read out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_seen <= 1'b0;
		end else if (start_pulse) begin
			byte_seen <= 1'b0;
		end else if (readout_fall && state == tape_check_pkg::st_data) begin
			byte_seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cyclic check register with its shift/XOR phase

	assign shift_en = check_fall & ~phase & write_mode;
	assign xor_en   = check_fall & phase & write_mode;
	assign check_input_bit = bus_data_bit & {9{forward_select & write_mode}};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
		end else if (general_reset || start_pulse) begin
			phase <= 1'b0;
		end else if (check_fall) begin
			phase <= ~phase;
		end
	end

	check_register #(
		.W (tape_check_pkg::CHAR_W)
	) u_check_register (
		.pclk            (pclk),
		.presetn         (presetn),
		.clear           (start_pulse),
		.shift_en        (shift_en),
		.xor_en          (xor_en),
		.check_input_bit (check_input_bit),
		.crc             (crc)
	);

	////////////////////////////////////////////////////////////////////////
	// Write register toward the station; blank slots send zeros

	always_comb begin
		next_wreg = tape_check_pkg::CHAR_RESET;
		case (state)
			tape_check_pkg::st_data: begin
				next_wreg = bus_data_bit;
			end
			tape_check_pkg::st_cyc_wait: begin
				if (count_equals_one) begin
					next_wreg = crc ^ ~tape_check_pkg::CYC_KEEP_MASK;
				end
			end
			tape_check_pkg::st_long_wait: begin
				if (count_equals_one) begin
					next_wreg = bus_data_bit |
					            tape_check_pkg::LONG_FORCE_MASK;
				end
			end
			tape_check_pkg::st_mark_wait: begin
				if (count_equals_one) begin
					next_wreg = bus_data_bit;
				end
			end
			default: begin
				next_wreg = tape_check_pkg::CHAR_RESET;
			end
		endcase
	end

	// Clear wins over load so a stage only holds a one until the next request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_reg <= tape_check_pkg::CHAR_RESET;
		end else if (write_char_request) begin
			write_reg <= tape_check_pkg::CHAR_RESET;
		end else if (readout_fall && write_mode) begin
			write_reg <= next_wreg;
		end
	end

	// Station samples these on its own deskewed clock
	assign station_write_bits = write_reg;

endmodule : tape_write_check_character_gen

/* tb/tape_station_model.sv */
module tape_station_model (
	input  wire logic [8:0] station_write_bits, // From write register
	output logic      [8:0] station_data        // Latched character
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_2m;
	// Station clock is free running and unrelated to pclk
	initial begin
		clk_2m = 1'b0;
		station_data = 9'h000;
		forever #250 clk_2m = ~clk_2m;
	end
	always @(posedge clk_2m) begin
		station_data <= station_write_bits;
	end
endmodule : tape_station_model

/* tb/tape_write_check_character_gen_assertions.sv */
module tape_check_checker (
	input wire logic       pclk,                     // Clock
	input wire logic       presetn,                  // Reset, low
	input wire logic       mem_readout_mode,         // Readout mode
	input wire logic       delay_end_tap,            // End tap
	input wire logic       write_char_request,       // Clear request
	input wire logic [8:0] station_write_bits,       // Write register
	input wire logic       buffer_request,           // Buffer request
	input wire logic       cyc_check_timing_strobe,  // Cyclic strobe
	input wire logic       long_check_timing_strobe, // Long strobe
	input wire logic       check_force,              // Force
	input wire logic       count_bit_a,              // Count a
	input wire logic       count_bit_b,              // Count b
	input wire logic       count_bit_c,              // Count c
	input wire logic       count_nonzero_flag,       // Not zero
	input wire logic       count_zero_flag,          // Zero
	input wire logic       count_equals_one,         // One
	input wire logic       not_writing_cyc_check,    // Not cyclic slot
	input wire logic       long_check_write_state    // Long state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence rd_fall;
		$past(delay_end_tap & mem_readout_mode)
			&& !(delay_end_tap & mem_readout_mode);
	endsequence
	// Both presets load a=b=1 whatever the count ends as
	sequence preset_four;
		check_force ##1 (count_nonzero_flag && count_bit_a && count_bit_b);
	endsequence
	a_cyc_preset: assert property (
		cyc_check_timing_strobe |-> preset_four
			##0 (!cyc_check_timing_strobe && !count_bit_c))
		else $error("cyclic preset wrong");
	a_long_preset: assert property (
		long_check_timing_strobe |-> preset_four
			##0 !long_check_timing_strobe)
		else $error("long preset wrong");
	a_cyc_cause: assert property (
		cyc_check_timing_strobe |-> count_zero_flag && not_writing_cyc_check)
		else $error("cyclic strobe without cause");
	a_long_cause: assert property (
		long_check_timing_strobe |-> count_zero_flag
			&& !cyc_check_timing_strobe)
		else $error("long strobe without cause");
	a_force_src: assert property (
		check_force |-> cyc_check_timing_strobe || long_check_timing_strobe)
		else $error("force without strobe");
	a_wreg_clear: assert property (
		write_char_request |=> station_write_bits == 9'h000)
		else $error("write register not cleared");
	a_long_char: assert property (
		rd_fall ##0 (long_check_write_state && count_equals_one
			&& !write_char_request) |=> (station_write_bits
			& tape_check_pkg::LONG_FORCE_MASK)
			== tape_check_pkg::LONG_FORCE_MASK)
		else $error("long character bits not forced");
	a_one_flags: assert property (
		count_equals_one |-> count_nonzero_flag && !count_bit_a
			&& !count_bit_b && !count_bit_c)
		else $error("count one flags wrong");
	a_zero_flags: assert property (
		count_zero_flag ^ count_nonzero_flag)
		else $error("zero flags disagree");
	a_breq_mark: assert property (
		long_check_timing_strobe && long_check_write_state
			|=> count_bit_c && !buffer_request)
		else $error("mark preset without count bit c");
endmodule : tape_check_checker

////////////////////////////////////////////////////////////////////////////////
bind tape_write_check_character_gen tape_check_checker chk_u (
	.pclk, .presetn, .mem_readout_mode, .delay_end_tap, .write_char_request,
	.station_write_bits, .buffer_request, .cyc_check_timing_strobe,
	.long_check_timing_strobe, .check_force, .count_bit_a, .count_bit_b,
	.count_bit_c, .count_nonzero_flag, .count_zero_flag, .count_equals_one,
	.not_writing_cyc_check, .long_check_write_state
);

/* tb/test_tape_write_check_character_gen.sv */
module test_tape_write_check_character_gen;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0]  bus_data_bit, station_write_bits, station_data, crc_m;
	logic [8:0]  last_exp;
	logic        mem_readout_mode, delay_early_tap, delay_end_tap;
	logic        write_char_request, readout_request_ff, no_priority;
	logic        byte_stored, buffer_request, cyc_check_timing_strobe;
	logic        long_check_timing_strobe, check_force, count_bit_a;
	logic        count_bit_b, count_bit_c, count_nonzero_flag;
	logic        count_zero_flag, count_equals_one, not_writing_cyc_check;
	logic        long_check_write_state, prev_rd, pend, err;
	logic [8:0]  expq[$];
	int          n_errors, comparisons, n_cyc, n_long;

	tape_write_check_character_gen dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bus_data_bit, .mem_readout_mode,
		.delay_early_tap, .delay_end_tap, .write_char_request,
		.readout_request_ff, .no_priority, .byte_stored,
		.station_write_bits, .buffer_request, .cyc_check_timing_strobe,
		.long_check_timing_strobe, .check_force, .count_bit_a,
		.count_bit_b, .count_bit_c, .count_nonzero_flag, .count_zero_flag,
		.count_equals_one, .not_writing_cyc_check, .long_check_write_state
	);
	tape_station_model station_u (
		.station_write_bits,
		.station_data
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			print_verdict();
		end else begin
			rd      = prdata;
			err     = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb

	function automatic logic [8:0] crc_step(input logic [8:0] c,
			input logic [8:0] d);
		logic [8:0] s;
		s = {c[7:0], c[8]} ^ ({9{c[8]}} & 9'h078);
		return s ^ d;
	endfunction : crc_step

	// Early tap gives the shift clock, end tap the XOR clock and load
	task automatic slot(input logic dat, input logic [8:0] b,
			input logic [8:0] exp);
		bus_data_bit     <= b;
		mem_readout_mode <= 1'b1;
		delay_early_tap  <= dat;
		@(posedge pclk);
		delay_early_tap  <= 1'b0;
		@(posedge pclk);
		delay_end_tap    <= 1'b1;
		@(posedge pclk);
		delay_end_tap    <= 1'b0;
		mem_readout_mode <= 1'b0;
		expq.push_back(exp);
		last_exp = exp;
		repeat (2) @(posedge pclk);
	endtask : slot

	task automatic blanks(input int k);
		repeat (k) slot(1'b0, 9'($urandom), 9'h000);
	endtask : blanks

	task automatic record(input logic [3:0] ctl, input int n);
		logic [8:0] b;
		apb(1'b1, 8'h00, {28'h0, ctl});
		apb(1'b1, 8'h00, {27'h0, 1'b1, ctl});
		crc_m  = 9'h000;
		n_cyc  = 0;
		n_long = 0;
		repeat (n) begin
			byte_stored <= 1'b1;
			@(posedge pclk);
			byte_stored <= 1'b0;
			@(posedge pclk);
		end
		repeat (n) begin
			b = 9'($urandom);
			slot(1'b1, b, b);
			crc_m = crc_step(crc_m, ctl[1] ? b : 9'h000);
		end
		apb(1'b0, 8'h08, 32'h0);
		check("check reg", rd, {23'h0, crc_m});
		check("breq", {31'h0, buffer_request}, 32'h1);
		blanks(3);
		slot(1'b0, b, crc_m ^ 9'h1d7);
		check("cyc strobes", 32'(n_cyc), 32'h1);
		blanks(3);
		b = 9'($urandom);
		slot(1'b0, b, b | 9'h06f);
		if (ctl[3]) begin
			// Eight-count preset lands on the edge that ended the slot
			@(posedge pclk);
			check("mark c", {31'h0, count_bit_c}, 32'h1);
			blanks(7);
			slot(1'b0, b, b);
		end
		check("long strobes", 32'(n_long), ctl[3] ? 32'h2 : 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		check("end state", {24'h0, rd[7:4], 1'b0, rd[2:0]}, 32'h0);
		check("done", {31'h0, rd[12]}, 32'h1);
		$display("test record %h done", ctl);
	endtask : record

	////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		if (pend) begin
			check("write bits", {23'h0, station_write_bits},
				{23'h0, expq.pop_front()});
		end
		pend    <= prev_rd & ~(delay_end_tap & mem_readout_mode);
		prev_rd <= delay_end_tap & mem_readout_mode;
		if (cyc_check_timing_strobe === 1'b1) n_cyc++;
		if (long_check_timing_strobe === 1'b1) n_long++;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		print_verdict();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, bus_data_bit} = '0;
		{mem_readout_mode, delay_early_tap, delay_end_tap} = '0;
		{write_char_request, byte_stored, prev_rd, pend} = '0;
		{readout_request_ff, no_priority} = 2'b11;
		{n_errors, comparisons, n_cyc, n_long} = '0;
		presetn = 1'b0;
		void'($urandom(32'h5d4a0b87));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("zero flag", {31'h0, count_zero_flag}, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		check("status reset", rd, 32'h0);
		check("no slverr", {31'h0, err}, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check("slverr", {31'h0, err}, 32'h1);
		check("unmapped read", rd, 32'h0);
		$display("test reset done");
		record(4'h7, 5);
		// More than one full station clock period so the latch must have fired
		repeat (30) @(posedge pclk);
		check("station", {23'h0, station_data}, {23'h0, last_exp});
		write_char_request <= 1'b1;
		@(posedge pclk);
		write_char_request <= 1'b0;
		repeat (2) @(posedge pclk);
		check("cleared", {23'h0, station_write_bits}, 32'h0);
		record(4'hb, 8);
		record(4'h5, 3);
		apb(1'b1, 8'h00, 32'h3);
		apb(1'b1, 8'h00, 32'h13);
		delay_early_tap <= 1'b1;
		@(posedge pclk);
		delay_early_tap <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h04, 32'h0);
		check("phase set", {31'h0, rd[11]}, 32'h1);
		apb(1'b1, 8'h00, 32'h23);
		apb(1'b0, 8'h04, 32'h0);
		check("phase clr", {28'h0, rd[11], rd[2:0]}, 32'h0);
		$display("test general reset done");
		print_verdict();
	end
endmodule : test_tape_write_check_character_gen
